// file: logic/eccgc_pkg.sv
// eccgc_pkg: constants and carrier types for the echo canceller group control block
// assumes one 100 MHz clock and 8 kHz sample strobes from the serial port logic
package eccgc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int FRAME_US = 125;
    localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;
    // tone and release timings counted in 8 kHz frames
    localparam int TONE_PLAIN_MS = 400;
    localparam int TONE_PHASE_MS = 1000;
    localparam int RELEASE_MS = 400;
    localparam int FRAMES_PER_MS = 8;
    localparam int TONE_PLAIN_FRAMES = TONE_PLAIN_MS * FRAMES_PER_MS;
    localparam int TONE_PHASE_FRAMES = TONE_PHASE_MS * FRAMES_PER_MS;
    localparam int RELEASE_FRAMES = RELEASE_MS * FRAMES_PER_MS;
    localparam int CNT_W = 14;
    // quiet codes per coding law
    localparam logic [15:0] QUIET_LINEAR = 16'h0000;
    localparam logic [7:0] QUIET_SIGN_MAG = 8'h80;
    localparam logic [7:0] QUIET_MU_LAW = 8'hFF;
    localparam logic [7:0] QUIET_A_LAW = 8'hD5;
    localparam logic [15:0] ZERO_CODE = 16'h0000;
    // pad codes: 0 is +9 dB, each step -3 dB, 7 is -12 dB
    localparam logic [2:0] PAD_MINUS_12 = 3'h7;
    localparam logic [3:0] NOISE_RATE_ADV_RST = 4'h5;
    localparam logic [7:0] NOISE_SCALE_ADV_RST = 8'h16;
    localparam int NOISE_SCALE_SHIFT = 4;

    typedef enum logic [1:0] {
        ECCGC_LAW_LINEAR = 2'h0,
        ECCGC_LAW_SIGN_MAG = 2'h1,
        ECCGC_LAW_MU = 2'h2,
        ECCGC_LAW_A = 2'h3
    } eccgc_law_t;

    typedef enum logic [1:0] {
        ECCGC_CFG_NORMAL = 2'h0,
        ECCGC_CFG_BACK_TO_BACK = 2'h1,
        ECCGC_CFG_EXTENDED = 2'h2
    } eccgc_cfg_t;

    typedef enum logic [2:0] {
        ECCGC_ST_ADAPT = 3'b001,
        ECCGC_ST_FROZEN = 3'b010,
        ECCGC_ST_BYPASS = 3'b100
    } eccgc_state_t;

    // per-canceller control bits
    typedef struct packed {
        logic residual_proc_select;
        logic noise_ramp_scheme_select;
        logic [3:0] noise_ramp_rate;
        logic [7:0] noise_scale;
        logic uncancelled_echo_guard_en;
        logic double_talk_guard_en;
        logic phase_reversal_disable;
        logic auto_tone_bypass;
        logic ringing_suppress_en;
        logic narrowband_detect_disable;
        logic offset_null_disable;
        logic legacy_pad;
        logic back_to_back_select;
        logic extended_delay_select;
        logic bypass;
        logic adapt_disable;
        logic [2:0] pad_rin;
        logic [2:0] pad_rout;
        logic [2:0] pad_sin;
        logic [2:0] pad_sout;
    } eccgc_ctrl_t;

    // per-frame detector observations from the signal path
    typedef struct packed {
        logic tone_2100;
        logic phase_reversal;
        logic tone_level_ok;
        logic quiet_low_band;
        logic quiet_high_band;
    } eccgc_obs_t;

    // per-canceller derived controls for the datapath
    typedef struct packed {
        logic advanced_proc;
        logic ramp_fast_low;
        logic [3:0] ramp_rate;
        logic [11:0] noise_gain;
        logic echo_guard;
        logic talk_guard;
        logic ringing_on;
        logic adapt_en;
        logic coeff_clear;
        logic bypass_path;
        logic offset_null_on;
        logic [2:0] pad_rin;
        logic [2:0] pad_rout;
        logic [2:0] pad_sin;
        logic [2:0] pad_sout;
    } eccgc_path_t;
endpackage

// file: logic/eccgc_tone_det.sv
// eccgc_tone_det: one disable-tone detector with latched status
// assumes frame_tick_in pulses once per 8 kHz frame
`timescale 1ns/1ps
module eccgc_tone_det import eccgc_pkg::*; (
    input wire logic ref_clk_in, // 100 MHz
    input wire logic reset_in, // sync, high
    input wire logic frame_tick_in, // frame strobe
    input wire logic plain_mode_in, // 1: plain tone mode
    input wire eccgc_obs_t obs_in, // per-frame observations
    output logic detected_out, // latched status
    output logic change_out // pulse on set or release
);
    logic [CNT_W-1:0] tone_cnt_reg;
    logic [CNT_W-1:0] quiet_cnt_reg;
    logic reversal_seen_reg;
    logic detected_reg;
    logic tone_ok;
    logic quiet_ok;
    logic trigger;
    logic release_now;

    assign tone_ok = obs_in.tone_2100 && obs_in.tone_level_ok;
    assign quiet_ok = obs_in.quiet_low_band && obs_in.quiet_high_band;
    assign trigger = plain_mode_in ?
        (tone_cnt_reg >= CNT_W'(TONE_PLAIN_FRAMES - 1)) :
        (tone_cnt_reg >= CNT_W'(TONE_PHASE_FRAMES - 1) &&
         (reversal_seen_reg || obs_in.phase_reversal));
    assign release_now = quiet_cnt_reg >= CNT_W'(RELEASE_FRAMES - 1);

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            tone_cnt_reg <= '0;
            reversal_seen_reg <= 1'b0;
        end else if (frame_tick_in) begin
            if (!tone_ok || detected_reg) begin
                tone_cnt_reg <= '0;
                reversal_seen_reg <= 1'b0;
            end else begin
                if (tone_cnt_reg != '1)
                    tone_cnt_reg <= tone_cnt_reg + 1'b1;
                if (obs_in.phase_reversal)
                    reversal_seen_reg <= 1'b1;
            end
        end
    end

    // once latched, only a long quiet spell releases it
    always_ff @(posedge ref_clk_in) begin
        if (reset_in)
            quiet_cnt_reg <= '0;
        else if (frame_tick_in) begin
            if (!detected_reg || !quiet_ok)
                quiet_cnt_reg <= '0;
            else if (quiet_cnt_reg != '1)
                quiet_cnt_reg <= quiet_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            detected_reg <= 1'b0;
            change_out <= 1'b0;
        end else begin
            change_out <= 1'b0;
            if (frame_tick_in && !detected_reg && tone_ok && trigger) begin
                detected_reg <= 1'b1;
                change_out <= 1'b1;
            end else if (frame_tick_in && detected_reg && quiet_ok && release_now) begin
                detected_reg <= 1'b0;
                change_out <= 1'b1;
            end
        end
    end

    assign detected_out = detected_reg;
endmodule // eccgc_tone_det

// file: logic/eccgc_group.sv
// eccgc_group: control logic of one group of two echo cancellers (a and b)
// assumes frame_tick_in once per 125 us frame; detectors deliver per-frame flags
`timescale 1ns/1ps
module eccgc_group import eccgc_pkg::*; #(
    parameter int NUM_CANCELLERS = 2
) (
    input wire logic ref_clk_in, // 100 MHz
    input wire logic reset_in, // sync, high
    input wire logic frame_tick_in, // one per 8 kHz frame
    input wire eccgc_law_t law_in, // pcm coding law
    input wire eccgc_ctrl_t ctrl_a_in, // canceller a controls
    input wire eccgc_ctrl_t ctrl_b_in, // canceller b controls
    input wire eccgc_obs_t [3:0] obs_in, // a rin, a sin, b rin, b sin
    input wire logic [1:0] narrowband_detector_in, // narrow-band hit per canceller
    input wire logic [1:0] status_read_in, // host read pulse, clears change flag
    input wire logic [15:0] rout_b_in, // canceller b receive-out sample
    input wire logic [15:0] sout_b_in, // canceller b send-out sample
    output logic [1:0] tone_detected_flag_out, // latched status per canceller
    output logic [1:0] tone_event_out, // sticky change per canceller
    output logic irq_n_out, // active-low interrupt
    output eccgc_cfg_t cfg_out, // group configuration
    output eccgc_path_t path_a_out, // canceller a datapath controls
    output eccgc_path_t path_b_out, // canceller b datapath controls
    output logic [15:0] rout_b_out, // b timeslot receive-out
    output logic [15:0] sout_b_out // b timeslot send-out
);
    eccgc_ctrl_t ctrl [NUM_CANCELLERS];
    eccgc_path_t path_next [NUM_CANCELLERS];
    eccgc_path_t path_reg [NUM_CANCELLERS];
    eccgc_state_t state_reg [NUM_CANCELLERS];
    logic [3:0] det;
    logic [3:0] det_change;
    logic [1:0] event_reg;
    logic [1:0] tone_any;
    logic [1:0] clear_busy_reg;
    logic [1:0] cancel_b_mode;
    eccgc_cfg_t cfg_reg;
    logic [15:0] quiet_code;
    logic [15:0] rout_b_reg;
    logic [15:0] sout_b_reg;

    assign ctrl[0] = ctrl_a_in;
    assign ctrl[1] = ctrl_b_in;

    // two detectors per canceller; a release waits for quiet on both inputs
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_det
            eccgc_tone_det u_det (
                .ref_clk_in(ref_clk_in),
                .reset_in(reset_in),
                .frame_tick_in(frame_tick_in),
                .plain_mode_in(ctrl[g/2].phase_reversal_disable),
                .obs_in({obs_in[g][4:2], obs_in[g/2*2][1:0] & obs_in[g/2*2+1][1:0]}),
                .detected_out(det[g]),
                .change_out(det_change[g])
            );
        end
    endgenerate

    // group configuration; b bit 0 is ignored, host keeps it zero
    always_ff @(posedge ref_clk_in) begin
        if (reset_in)
            cfg_reg <= ECCGC_CFG_NORMAL;
        else if (ctrl_a_in.back_to_back_select && ctrl_b_in.back_to_back_select)
            cfg_reg <= ECCGC_CFG_BACK_TO_BACK;
        else if (ctrl_a_in.extended_delay_select)
            cfg_reg <= ECCGC_CFG_EXTENDED;
        else
            cfg_reg <= ECCGC_CFG_NORMAL;
    end
    assign cfg_out = cfg_reg;

    always_comb begin
        case (law_in)
            ECCGC_LAW_LINEAR: quiet_code = QUIET_LINEAR;
            ECCGC_LAW_SIGN_MAG: quiet_code = {8'h00, QUIET_SIGN_MAG};
            ECCGC_LAW_MU: quiet_code = {8'h00, QUIET_MU_LAW};
            default: quiet_code = {8'h00, QUIET_A_LAW};
        endcase
    end

    // b timeslot: zero code in back-to-back, quiet code in extended delay
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rout_b_reg <= ZERO_CODE;
            sout_b_reg <= ZERO_CODE;
        end else if (cfg_reg == ECCGC_CFG_BACK_TO_BACK) begin
            rout_b_reg <= ZERO_CODE;
            sout_b_reg <= ZERO_CODE;
        end else if (cfg_reg == ECCGC_CFG_EXTENDED) begin
            rout_b_reg <= quiet_code;
            sout_b_reg <= quiet_code;
        end else begin
            rout_b_reg <= rout_b_in;
            sout_b_reg <= sout_b_in;
        end
    end
    assign rout_b_out = rout_b_reg;
    assign sout_b_out = sout_b_reg;

    // b canceller adapts in normal and back-to-back mode, never in extended delay
    assign cancel_b_mode[0] = 1'b1;
    assign cancel_b_mode[1] = (cfg_reg != ECCGC_CFG_EXTENDED);

    generate
        for (g = 0; g < NUM_CANCELLERS; g++) begin : g_ch
            assign tone_any[g] = det[2*g] || det[2*g+1];

            // sticky change flag: a new event wins over a host read
            always_ff @(posedge ref_clk_in) begin
                if (reset_in)
                    event_reg[g] <= 1'b0;
                else if (det_change[2*g] || det_change[2*g+1])
                    event_reg[g] <= 1'b1;
                else if (status_read_in[g])
                    event_reg[g] <= 1'b0;
            end

            // functional state; host bypass or auto tone bypass
            always_ff @(posedge ref_clk_in) begin
                if (reset_in)
                    state_reg[g] <= ECCGC_ST_ADAPT;
                else begin
                    case (state_reg[g])
                        ECCGC_ST_ADAPT: begin
                            if (ctrl[g].bypass ||
                                (ctrl[g].auto_tone_bypass && tone_any[g]))
                                state_reg[g] <= ECCGC_ST_BYPASS;
                            else if (ctrl[g].adapt_disable)
                                state_reg[g] <= ECCGC_ST_FROZEN;
                        end
                        ECCGC_ST_FROZEN: begin
                            if (ctrl[g].bypass)
                                state_reg[g] <= ECCGC_ST_BYPASS;
                            else if (!ctrl[g].adapt_disable)
                                state_reg[g] <= ECCGC_ST_ADAPT;
                        end
                        ECCGC_ST_BYPASS: begin
                            // auto bypass holds until the tone status releases
                            if (!ctrl[g].bypass &&
                                !(ctrl[g].auto_tone_bypass && tone_any[g]))
                                state_reg[g] <= ctrl[g].adapt_disable ?
                                    ECCGC_ST_FROZEN : ECCGC_ST_ADAPT;
                        end
                        default: state_reg[g] <= ECCGC_ST_ADAPT;
                    endcase
                end
            end

            // coefficient clear held after bypass until the next frame tick
            always_ff @(posedge ref_clk_in) begin
                if (reset_in)
                    clear_busy_reg[g] <= 1'b0;
                else if (state_reg[g] == ECCGC_ST_BYPASS)
                    clear_busy_reg[g] <= 1'b1;
                else if (frame_tick_in)
                    clear_busy_reg[g] <= 1'b0;
            end

            always_comb begin
                path_next[g].advanced_proc = ctrl[g].residual_proc_select;
                path_next[g].ramp_fast_low = ctrl[g].noise_ramp_scheme_select;
                // scheme 1 uses rate as is, scheme 0 inverted so bigger is faster
                path_next[g].ramp_rate = ctrl[g].noise_ramp_scheme_select ?
                    ctrl[g].noise_ramp_rate : ~ctrl[g].noise_ramp_rate;
                path_next[g].noise_gain = {ctrl[g].noise_scale, 4'h0} >>
                    NOISE_SCALE_SHIFT;
                path_next[g].echo_guard = ctrl[g].residual_proc_select &&
                    ctrl[g].uncancelled_echo_guard_en;
                path_next[g].talk_guard = ctrl[g].residual_proc_select &&
                    ctrl[g].double_talk_guard_en;
                path_next[g].ringing_on = ctrl[g].ringing_suppress_en;
                path_next[g].adapt_en = (state_reg[g] == ECCGC_ST_ADAPT) &&
                    cancel_b_mode[g] &&
                    !(narrowband_detector_in[g] &&
                      !ctrl[g].narrowband_detect_disable);
                path_next[g].coeff_clear = (state_reg[g] == ECCGC_ST_BYPASS) ||
                    clear_busy_reg[g];
                path_next[g].bypass_path = (state_reg[g] == ECCGC_ST_BYPASS);
                path_next[g].offset_null_on = !ctrl[g].offset_null_disable;
                path_next[g].pad_rin = ctrl[g].legacy_pad ?
                    PAD_MINUS_12 : ctrl[g].pad_rin;
                path_next[g].pad_rout = ctrl[g].pad_rout;
                path_next[g].pad_sin = ctrl[g].pad_sin;
                path_next[g].pad_sout = ctrl[g].pad_sout;
            end

            always_ff @(posedge ref_clk_in) begin
                if (reset_in)
                    path_reg[g] <= '0;
                else
                    path_reg[g] <= path_next[g];
            end
        end
    endgenerate

    assign path_a_out = path_reg[0];
    assign path_b_out = path_reg[1];
    assign tone_detected_flag_out = tone_any;
    assign tone_event_out = event_reg;
    assign irq_n_out = ~(|event_reg);
endmodule // eccgc_group

// file: test/eccgc_sig_model.sv
// eccgc_sig_model: frame strobe and tone/level detectors feeding the group
// assumes the bench picks tone lanes; frames tick every TICK_DIV cycles
`timescale 1ns/1ps
module eccgc_sig_model import eccgc_pkg::*; #(
    parameter int TICK_DIV = 2,
    parameter int REV_FRAMES = 3600
) (
    input wire logic ref_clk_in, // clock
    input wire logic reset_in, // sync reset
    input wire logic [3:0] tone_lanes_in, // lanes with tone
    input wire logic reversal_in, // add reversals
    output logic frame_tick_out, // frame strobe
    output eccgc_obs_t [3:0] obs_out // observations
);
    int div_reg;
    int rev_reg;
    always_ff @(posedge ref_clk_in) begin
        div_reg <= (reset_in || div_reg == TICK_DIV - 1) ? 0 : div_reg + 1;
        frame_tick_out <= !reset_in && div_reg == TICK_DIV - 1;
    end
    // one reversal every 450 ms worth of frames
    always_ff @(posedge ref_clk_in) begin
        if (reset_in || (frame_tick_out && rev_reg == REV_FRAMES - 1)) begin
            rev_reg <= 0;
        end else if (frame_tick_out) begin
            rev_reg <= rev_reg + 1;
        end
    end
    // off-tick values are inverted: only the tick frame is trustworthy
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            obs_out[i] = {tone_lanes_in[i], tone_lanes_in[i] && reversal_in && rev_reg == 0,
                tone_lanes_in[i], !tone_lanes_in[i], !tone_lanes_in[i]};
            if (!frame_tick_out) begin
                obs_out[i] = ~obs_out[i];
            end
        end
    end
endmodule // eccgc_sig_model

// file: test/eccgc_group_asserts.sv
// eccgc_group_asserts: port-level checks of the group control block
// assumes a single clock domain and sync active-high reset
`timescale 1ns/1ps
module eccgc_group_asserts import eccgc_pkg::*; (
    input wire logic ref_clk_in, // clock
    input wire logic reset_in, // reset
    input wire logic frame_tick_in, // strobe
    input wire eccgc_law_t law_in, // law
    input wire eccgc_ctrl_t ctrl_a_in, // a ctrl
    input wire eccgc_ctrl_t ctrl_b_in, // b ctrl
    input wire eccgc_obs_t [3:0] obs_in, // obs
    input wire logic [1:0] narrowband_detector_in, // nb hit
    input wire logic [1:0] status_read_in, // read
    input wire logic [15:0] rout_b_in, // b rout in
    input wire logic [15:0] sout_b_in, // b sout in
    input wire logic [1:0] tone_detected_flag_out, // flags
    input wire logic [1:0] tone_event_out, // events
    input wire logic irq_n_out, // irq
    input wire eccgc_cfg_t cfg_out, // cfg
    input wire eccgc_path_t path_a_out, // path a
    input wire eccgc_path_t path_b_out, // path b
    input wire logic [15:0] rout_b_out, // b rout
    input wire logic [15:0] sout_b_out // b sout
);
    logic bb;
    logic [15:0] quiet;
    assign bb = ctrl_a_in.back_to_back_select && ctrl_b_in.back_to_back_select;
    always_comb begin
        case (law_in)
            ECCGC_LAW_LINEAR: quiet = QUIET_LINEAR;
            ECCGC_LAW_SIGN_MAG: quiet = {8'h00, QUIET_SIGN_MAG};
            ECCGC_LAW_MU: quiet = {8'h00, QUIET_MU_LAW};
            default: quiet = {8'h00, QUIET_A_LAW};
        endcase
    end
    default clocking dc @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    a_irq_from_event: assert property (irq_n_out == !(|tone_event_out))
        else $error("irq not tied to event flags");
    a_event_on_change: assert property ($changed(tone_detected_flag_out[0]) |=>
        tone_event_out[0])
        else $error("status change without event");
    a_bb_select: assert property (bb |=> cfg_out == ECCGC_CFG_BACK_TO_BACK)
        else $error("back-to-back not selected");
    a_ext_select: assert property (!bb && ctrl_a_in.extended_delay_select |=>
        cfg_out == ECCGC_CFG_EXTENDED)
        else $error("extended delay not selected");
    a_normal_select: assert property (!bb && !ctrl_a_in.extended_delay_select |=>
        cfg_out == ECCGC_CFG_NORMAL)
        else $error("normal not selected");
    a_bb_zero_code: assert property (cfg_out == ECCGC_CFG_BACK_TO_BACK [*2] |->
        rout_b_out == ZERO_CODE && sout_b_out == ZERO_CODE)
        else $error("b slot not zero in back-to-back");
    a_ext_quiet_code: assert property (cfg_out == ECCGC_CFG_EXTENDED ##1
        (cfg_out == ECCGC_CFG_EXTENDED && $stable(law_in)) |-> rout_b_out == quiet &&
        sout_b_out == quiet)
        else $error("b slot not quiet in extended");
    a_legacy_pad: assert property (ctrl_a_in.legacy_pad |=>
        path_a_out.pad_rin == PAD_MINUS_12)
        else $error("legacy pad not applied");
    a_nb_halts: assert property (narrowband_detector_in[0] &&
        !ctrl_a_in.narrowband_detect_disable |=> !path_a_out.adapt_en)
        else $error("adaptation runs on narrow-band");
    a_auto_bypass: assert property (ctrl_a_in.auto_tone_bypass &&
        !ctrl_a_in.adapt_disable && $rose(tone_detected_flag_out[0]) |->
        ##[1:3] path_a_out.bypass_path)
        else $error("auto bypass missing");
    a_bypass_clears: assert property (path_a_out.bypass_path ||
        $fell(path_a_out.bypass_path) |-> path_a_out.coeff_clear)
        else $error("bypass without coefficient clear");
endmodule // eccgc_group_asserts
bind eccgc_group eccgc_group_asserts eccgc_group_asserts_inst (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .frame_tick_in(frame_tick_in),
    .law_in(law_in), .ctrl_a_in(ctrl_a_in), .ctrl_b_in(ctrl_b_in), .obs_in(obs_in),
    .narrowband_detector_in(narrowband_detector_in), .status_read_in(status_read_in),
    .rout_b_in(rout_b_in), .sout_b_in(sout_b_in), .tone_event_out(tone_event_out),
    .tone_detected_flag_out(tone_detected_flag_out), .irq_n_out(irq_n_out),
    .cfg_out(cfg_out), .path_a_out(path_a_out), .path_b_out(path_b_out),
    .rout_b_out(rout_b_out), .sout_b_out(sout_b_out));

// file: test/tb_top.sv
// tb_top: self-checking bench for the group control block
// assumes the signal model delivers frame ticks every second cycle
`timescale 1ns/1ps
module tb_top;
    import eccgc_pkg::*;
    typedef struct {int sel; logic [63:0] val; logic [63:0] msk;} eccgc_note_t;
    logic ref_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [3:0] lanes = 4'h0;
    logic rev_en = 1'b0;
    logic tick;
    eccgc_obs_t [3:0] obs;
    eccgc_law_t law = ECCGC_LAW_LINEAR;
    eccgc_ctrl_t ca = '0;
    eccgc_ctrl_t cb = '0;
    logic [1:0] nb = 2'h0;
    logic [1:0] rd = 2'h0;
    logic [15:0] rin_b = 16'h0000;
    logic [15:0] sin_b = 16'h0000;
    logic [1:0] flag;
    logic [1:0] evt;
    logic irq_n;
    eccgc_cfg_t cfg;
    eccgc_path_t pa;
    eccgc_path_t pb;
    logic [15:0] rout_b;
    logic [15:0] sout_b;
    int miscompares = 0;
    int check_count = 0;
    eccgc_note_t notes[$];
    always #5 ref_clk_in = ~ref_clk_in;
    eccgc_sig_model eccgc_sig_model_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .tone_lanes_in(lanes), .reversal_in(rev_en), .frame_tick_out(tick), .obs_out(obs));
    eccgc_group eccgc_group_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .frame_tick_in(tick), .law_in(law), .ctrl_a_in(ca), .ctrl_b_in(cb), .obs_in(obs),
        .narrowband_detector_in(nb), .status_read_in(rd), .rout_b_in(rin_b),
        .sout_b_in(sin_b), .tone_detected_flag_out(flag), .tone_event_out(evt),
        .irq_n_out(irq_n), .cfg_out(cfg), .path_a_out(pa), .path_b_out(pb),
        .rout_b_out(rout_b), .sout_b_out(sout_b));
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic note(input int sel, input logic [63:0] val, input logic [63:0] msk);
        eccgc_note_t n;
        n.sel = sel;
        n.val = val;
        n.msk = msk;
        notes.push_back(n);
    endtask
    function automatic logic [63:0] look(input int sel);
        case (sel)
            0: return 64'(flag);
            1: return 64'(evt);
            2: return 64'(irq_n);
            3: return 64'(cfg);
            4: return 64'(rout_b);
            5: return 64'(sout_b);
            6: return 64'(pa);
            default: return 64'(pb);
        endcase
    endfunction
    // outputs are registers or gates on registers, so mid-cycle is a settled place to look
    always @(negedge ref_clk_in) begin
        eccgc_note_t n;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            check(look(n.sel) & n.msk, n.val & n.msk);
        end
    end
    function automatic logic [15:0] quiet_of(input eccgc_law_t l);
        return l == ECCGC_LAW_LINEAR ? QUIET_LINEAR : l == ECCGC_LAW_SIGN_MAG ?
            {8'h00, QUIET_SIGN_MAG} : l == ECCGC_LAW_MU ? {8'h00, QUIET_MU_LAW} :
            {8'h00, QUIET_A_LAW};
    endfunction
    function automatic eccgc_path_t pmodel(input eccgc_ctrl_t c, input logic hit);
        eccgc_path_t p;
        p = '0;
        p.advanced_proc = c.residual_proc_select;
        p.ramp_fast_low = c.noise_ramp_scheme_select;
        p.ramp_rate = c.noise_ramp_scheme_select ? c.noise_ramp_rate : ~c.noise_ramp_rate;
        p.noise_gain = 12'(c.noise_scale);
        p.echo_guard = c.residual_proc_select && c.uncancelled_echo_guard_en;
        p.talk_guard = c.residual_proc_select && c.double_talk_guard_en;
        p.ringing_on = c.ringing_suppress_en;
        p.adapt_en = !c.bypass && !c.adapt_disable && !(hit && !c.narrowband_detect_disable);
        p.bypass_path = c.bypass;
        p.offset_null_on = !c.offset_null_disable;
        p.pad_rin = c.legacy_pad ? PAD_MINUS_12 : c.pad_rin;
        p.pad_rout = c.pad_rout;
        p.pad_sin = c.pad_sin;
        p.pad_sout = c.pad_sout;
        return p;
    endfunction
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk_in);
        #1;
    endtask
    // counts sampled frame ticks until the flag reaches val
    task automatic wait_flag(input int idx, input logic val, output int n);
        n = 0;
        for (int i = 0; i < 40000 && flag[idx] !== val; i++) begin
            @(posedge ref_clk_in);
            if (tick) n++;
        end
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #600000;
        miscompares++;
        stop_test();
    end
    initial begin
        int n;
        eccgc_path_t ep;
        eccgc_path_t em;
        eccgc_cfg_t ec;
        void'($urandom(26));
        step(4);
        reset_in = 1'b0;
        step(1);
        note(2, 64'h1, '1);
        note(3, 64'(ECCGC_CFG_NORMAL), '1);
        for (int i = 0; i < 48; i++) begin
            ca = $bits(eccgc_ctrl_t)'({$urandom, $urandom});
            cb = $bits(eccgc_ctrl_t)'({$urandom, $urandom});
            ca.auto_tone_bypass = 1'b0;
            cb.auto_tone_bypass = 1'b0;
            nb = 2'($urandom);
            law = eccgc_law_t'(2'($urandom));
            rin_b = 16'($urandom);
            sin_b = 16'($urandom);
            step(3);
            ec = (ca.back_to_back_select && cb.back_to_back_select) ? ECCGC_CFG_BACK_TO_BACK :
                ca.extended_delay_select ? ECCGC_CFG_EXTENDED : ECCGC_CFG_NORMAL;
            note(3, 64'(ec), '1);
            note(4, 64'(ec == ECCGC_CFG_BACK_TO_BACK ? ZERO_CODE :
                ec == ECCGC_CFG_EXTENDED ? quiet_of(law) : rin_b), '1);
            note(5, 64'(ec == ECCGC_CFG_BACK_TO_BACK ? ZERO_CODE :
                ec == ECCGC_CFG_EXTENDED ? quiet_of(law) : sin_b), '1);
            em = '1;
            em.coeff_clear = 1'b0;
            ep = pmodel(ca, nb[0]);
            note(6, 64'(ep), 64'(em));
            ep = pmodel(cb, nb[1]);
            ep.adapt_en &= ec != ECCGC_CFG_EXTENDED;
            note(7, 64'(ep), 64'(em));
        end
        ca = '0;
        cb = '0;
        nb = 2'h0;
        ca.phase_reversal_disable = 1'b1;
        lanes = 4'b0010;
        wait_flag(0, 1'b1, n);
        check(n, TONE_PLAIN_FRAMES);
        step(1);
        note(1, 64'h1, '1);
        note(2, 64'h0, '1);
        ca.bypass = 1'b1; // host takes the channel to bypass
        rd = 2'b01;
        step(1);
        rd = 2'b00;
        step(4);
        note(1, 64'h0, '1);
        ep = '0;
        ep.bypass_path = 1'b1;
        note(6, 64'(ep), 64'(ep));
        ca.bypass = 1'b0;
        lanes = 4'b0000;
        wait_flag(0, 1'b0, n);
        check(n, RELEASE_FRAMES);
        step(1);
        note(1, 64'h1, '1);
        note(2, 64'h0, '1);
        rd = 2'b01;
        step(1);
        rd = 2'b00;
        rev_en = 1'b1;
        lanes = 4'b0100;
        wait_flag(1, 1'b1, n);
        check(n, TONE_PHASE_FRAMES);
        note(1, 64'h2, '1);
        lanes = 4'b0000;
        rev_en = 1'b0;
        wait_flag(1, 1'b0, n);
        check(n, RELEASE_FRAMES);
        rd = 2'b10;
        step(1);
        rd = 2'b00;
        ca.auto_tone_bypass = 1'b1;
        lanes = 4'b0001;
        wait_flag(0, 1'b1, n);
        step(3);
        ep = '0;
        ep.bypass_path = 1'b1;
        ep.coeff_clear = 1'b1;
        em = ep;
        em.adapt_en = 1'b1;
        note(6, 64'(ep), 64'(em));
        step(2);
        stop_test();
    end
endmodule // tb_top
